// ---- rtl/wdk_pkg.sv ----
// Purpose: constants and types for the watchdog block with key lock
// Assumes: single 100 MHz clock, AXI4-Lite register access
// Notes: behaviour list below
// Behaviour
// - writing 1 to counter clear resets counter; 0 ignored; reads as 0
// - run/stop code 0xa stops, other values run; resets to 0xa
// - after a non-stop value is written, the run/stop field reads 0x0
// - counter is 10-bit up counter advanced per tick; overflow after 1,024 ticks
// - overflow of the running counter asserts a system reset request
// - after a clear, counting restarts from zero; the prescaler keeps its phase, so the first tick can come early
// - watchdog keeps counting in halt state
// - in sleep, counting continues while the selected source runs
// - if the selected source stops in sleep, the counter holds its value
// - debug run bit: 1 keeps tick running in debug, 0 suspends it
// - suspended in debug, state is kept and counting resumes afterwards
// - source select: 0 internal, 1 low-speed crystal, 2 high-speed, 3 external
// - divider 1/2048..1/16384 on internal/high-speed, 1/128 crystal, 1/1 external
// - an unimplemented clock source cannot be selected
package wdk_pkg;
	localparam logic [15:0] WDK_KEY_UNLOCK = 16'h0096;
	localparam logic [3:0] WDK_RUN_STOP = 4'ha;
	localparam logic [3:0] WDK_RUN_READ = 4'h0;
	localparam int WDK_CNT_W = 10;
	localparam logic [11:0] WDK_OFF_CLK = 12'h000;
	localparam logic [11:0] WDK_OFF_CTL = 12'h004;
	localparam logic [11:0] WDK_OFF_KEY = 12'h008;
	localparam logic [11:0] WDK_OFF_STAT = 12'h00c;
	localparam int WDK_DEBUG_RUN_ENABLE_BIT = 8;
	localparam int WDK_DIV_LSB = 4;
	localparam int WDK_SRC_LSB = 0;
	localparam int WDK_CLR_BIT = 4;
	localparam int WDK_RUN_LSB = 0;
	localparam logic [1:0] WDK_SRC_INTERNAL_OSCILLATOR = 2'h0;
	localparam logic [1:0] WDK_SRC_XTAL = 2'h1;
	localparam logic [1:0] WDK_SRC_HSOSC = 2'h2;
	localparam logic [1:0] WDK_SRC_EXT = 2'h3;
	localparam logic [3:0] WDK_SRC_PRESENT = 4'hf;
	localparam int WDK_PRE_W = 14;
	localparam logic [13:0] WDK_XTAL_DIV_MASK = 14'h007f;
	localparam logic [1:0] WDK_RESP_OKAY = 2'h0;
	localparam logic [1:0] WDK_RESP_SLVERR = 2'h2;
	localparam logic [3:0] WDK_PRE_MSB_BASE = 4'ha;
	typedef struct packed {
		logic debug_run_enable;
		logic [1:0] divider_select;
		logic [1:0] source_select;
	} wdk_clk_cfg_s;
endpackage : wdk_pkg

// ---- rtl/wdk_tick_gen.sv ----
// Purpose: divided watchdog tick from the selected source
// Assumes: source enables are one-cycle pulses synchronous to i_clk
// Notes: ticks only while the selected source pulses
`timescale 1ns/100ps
module wdk_tick_gen
	import wdk_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_src_pulse,
	input wire logic i_gate,
	input wire wdk_clk_cfg_s i_cfg,
	output logic o_tick
);
	// ==========================================
	// prescaler
	logic [WDK_PRE_W-1:0] pre_reg;
	logic src_pulse;
	logic [WDK_PRE_W-1:0] mask;
	assign src_pulse = i_src_pulse[i_cfg.source_select] & i_gate;
	always_comb begin
		unique case (i_cfg.source_select)
			WDK_SRC_XTAL: mask = WDK_XTAL_DIV_MASK;
			WDK_SRC_EXT: mask = '0;
			default: mask = WDK_PRE_W'((32'h1 << (WDK_PRE_MSB_BASE + 4'(i_cfg.divider_select)
				+ 4'h1)) - 32'h1);
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pre_reg <= '0;
		end else if (src_pulse) begin
			pre_reg <= ((pre_reg & mask) == mask) ? '0 : pre_reg + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= src_pulse && ((pre_reg & mask) == mask);
		end
	end
endmodule : wdk_tick_gen

// ---- rtl/wdk_watchdog.sv ----
// Purpose: watchdog with key-locked registers over AXI4-Lite
// Assumes: i_src_pulse carries one enable pulse per source edge
// Notes: reset request is sticky until block reset
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module wdk_watchdog
	import wdk_pkg::*;
#(
	parameter int CNT_W = WDK_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_src_pulse,
	input wire logic i_debug,
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_sys_reset_req
);
	// ==========================================
	// write channel capture
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	assign wr_go = aw_hold_reg && w_hold_reg && !o_bvalid;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= '0;
		end else if (o_awready && i_awvalid) begin
			aw_hold_reg <= 1'b1;
			awaddr_reg <= i_awaddr;
		end else if (wr_go) begin
			aw_hold_reg <= 1'b0;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			w_hold_reg <= 1'b0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (o_wready && i_wvalid) begin
			w_hold_reg <= 1'b1;
			wdata_reg <= i_wdata;
			wstrb_reg <= i_wstrb;
		end else if (wr_go) begin
			w_hold_reg <= 1'b0;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
		end else begin
			o_awready <= !aw_hold_reg && !(o_awready && i_awvalid);
			o_wready <= !w_hold_reg && !(o_wready && i_wvalid);
		end
	end
	// ==========================================
	// register decode
	logic [15:0] key_reg;
	logic unlocked;
	logic wr_lo;
	logic wr_hi;
	logic wr_clk;
	logic wr_ctl;
	logic wr_key;
	logic wr_ok;
	assign unlocked = (key_reg == WDK_KEY_UNLOCK);
	assign wr_lo = wr_go && wstrb_reg[0];
	assign wr_hi = wr_go && wstrb_reg[1];
	assign wr_clk = (awaddr_reg == WDK_OFF_CLK) && unlocked;
	assign wr_ctl = (awaddr_reg == WDK_OFF_CTL) && unlocked;
	assign wr_key = (awaddr_reg == WDK_OFF_KEY);
	assign wr_ok = (awaddr_reg == WDK_OFF_CLK) || (awaddr_reg == WDK_OFF_CTL) || wr_key
		|| (awaddr_reg == WDK_OFF_STAT);
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			key_reg <= '0;
		end else begin
			if (wr_key && wr_lo) begin
				key_reg[7:0] <= wdata_reg[7:0];
			end
			if (wr_key && wr_hi) begin
				key_reg[15:8] <= wdata_reg[15:8];
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_bvalid <= 1'b0;
			o_bresp <= WDK_RESP_OKAY;
		end else if (wr_go) begin
			o_bvalid <= 1'b1;
			o_bresp <= wr_ok ? WDK_RESP_OKAY : WDK_RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end
	// ==========================================
	// configuration and control fields
	wdk_clk_cfg_s cfg_reg;
	logic [3:0] run_reg;
	logic clr_pulse;
	logic [1:0] src_new;
	logic running;
	assign src_new = wdata_reg[WDK_SRC_LSB +: 2];
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cfg_reg <= '0;
		end else begin
			if (wr_clk && wr_hi) begin
				cfg_reg.debug_run_enable <= wdata_reg[WDK_DEBUG_RUN_ENABLE_BIT];
			end
			if (wr_clk && wr_lo) begin
				cfg_reg.divider_select <= wdata_reg[WDK_DIV_LSB +: 2];
				if (WDK_SRC_PRESENT[src_new]) begin
					cfg_reg.source_select <= src_new;
				end
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			run_reg <= WDK_RUN_STOP;
		end else if (wr_ctl && wr_lo) begin
			run_reg <= wdata_reg[WDK_RUN_LSB +: 4];
		end
	end
	assign clr_pulse = wr_ctl && wr_lo && wdata_reg[WDK_CLR_BIT];
	assign running = (run_reg != WDK_RUN_STOP);
	// ==========================================
	// tick and counter
	logic tick;
	logic [CNT_W-1:0] cnt_reg;
	// halt and sleep are not inputs: only debug and source activity gate the tick
	wdk_tick_gen u_tick (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_src_pulse(i_src_pulse),
		.i_gate(!i_debug || cfg_reg.debug_run_enable),
		.i_cfg(cfg_reg),
		.o_tick(tick)
	);
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_reg <= '0;
		end else if (clr_pulse) begin
			cnt_reg <= '0;
		end else if (running && tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_sys_reset_req <= 1'b0;
		end else if (running && tick && !clr_pulse && (&cnt_reg)) begin
			o_sys_reset_req <= 1'b1;
		end
	end
	// ==========================================
	// read channel
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_val = '0;
		rd_ok = 1'b1;
		unique case (i_araddr)
			WDK_OFF_CLK: begin
				rd_val[WDK_DEBUG_RUN_ENABLE_BIT] = cfg_reg.debug_run_enable;
				rd_val[WDK_DIV_LSB +: 2] = cfg_reg.divider_select;
				rd_val[WDK_SRC_LSB +: 2] = cfg_reg.source_select;
			end
			WDK_OFF_CTL: begin
				rd_val[WDK_RUN_LSB +: 4] = running ? WDK_RUN_READ : run_reg;
			end
			WDK_OFF_KEY: rd_val[15:0] = key_reg;
			WDK_OFF_STAT: rd_val[CNT_W-1:0] = cnt_reg;
			default: rd_ok = 1'b0;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_arready <= 1'b0;
		end else begin
			o_arready <= !o_rvalid && !(o_arready && i_arvalid);
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= WDK_RESP_OKAY;
		end else if (o_arready && i_arvalid) begin
			o_rvalid <= 1'b1;
			o_rdata <= rd_val;
			o_rresp <= rd_ok ? WDK_RESP_OKAY : WDK_RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule : wdk_watchdog

// ---- sim/wdk_watchdog_properties.sv ----
// Purpose: port checks for the watchdog
// Assumes: bound to wdk_watchdog
// Notes: bus timing and reset request
`timescale 1ns/100ps
module wdk_watchdog_properties
	import wdk_pkg::*;
#(
	parameter int CNT_W = WDK_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_src_pulse,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic o_sys_reset_req
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// ==========
	// properties
	sequence s_wr_both;
		i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid;
	endsequence
	property p_b_lat; s_wr_both |-> ##[2:3] o_bvalid; endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer not held");
	property p_r_lat; i_arvalid && o_arready |-> ##[1:2] o_rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_ar; o_rvalid |-> !o_arready; endproperty
	a_r_ar: assert property (p_r_ar) else $error("read taken while busy");
	// readies may rise again while the answer waits; they must drop after a taken write
	property p_b_rdy; s_wr_both |=> !o_awready && !o_wready; endproperty
	a_b_rdy: assert property (p_b_rdy) else $error("write taken while busy");
	property p_req_hold; o_sys_reset_req |=> o_sys_reset_req; endproperty
	a_req_hold: assert property (p_req_hold) else $error("reset request lost");
	// overflow needs a source pulse; a silent source holds the count
	property p_req_src;
		$rose(o_sys_reset_req) |-> $past(i_src_pulse, 2) != 4'h0 || $past(i_src_pulse, 3) != 4'h0;
	endproperty
	a_req_src: assert property (p_req_src) else $error("reset without tick");
endmodule : wdk_watchdog_properties

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the watchdog
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes: source pulses driven directly
`timescale 1ns/100ps
module testbench;
	import wdk_pkg::*;
	localparam logic [1:0] OK = WDK_RESP_OKAY;
	localparam logic [1:0] ER = WDK_RESP_SLVERR;
	localparam logic [11:0] CF = WDK_OFF_CLK;
	localparam logic [11:0] CT = WDK_OFF_CTL;
	localparam logic [11:0] ST = WDK_OFF_STAT;
	logic i_clk = 0, i_rst_b = 0, i_debug = 0, i_awvalid = 0, i_wvalid = 0;
	logic i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic [3:0] i_src_pulse = 4'h0, i_wstrb = 4'h3;
	logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sys_reset_req;
	logic [1:0] o_bresp, o_rresp;
	int err_count = 0, checks = 0;
	always #5 i_clk = ~i_clk;
	wdk_watchdog #(.CNT_W(WDK_CNT_W)) u_dut (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_src_pulse(i_src_pulse),
		.i_debug(i_debug),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_sys_reset_req(o_sys_reset_req)
	);
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
		int n;
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= {16'h0, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		if (n == 40) begin
			err_count++;
			$display("BAD bvalid exp %0d got %0d", 1, 0);
			print_verdict;
		end
		chk("bresp", {30'h0, o_bresp}, {30'h0, er});
		i_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		if (n == 40) begin
			err_count++;
			$display("BAD rvalid exp %0d got %0d", 1, 0);
			print_verdict;
		end
		chk("rdata", o_rdata, ed);
		chk("rresp", {30'h0, o_rresp}, {30'h0, er});
		i_rready <= 1'b0;
	endtask : rd
	// one pulse every other cycle, then let the tick land
	task automatic pls(input logic [3:0] m, input int k);
		repeat (k) begin
			@(posedge i_clk);
			i_src_pulse <= m;
			@(posedge i_clk);
			i_src_pulse <= 4'h0;
		end
		repeat (4) @(posedge i_clk);
	endtask : pls
	// ==========
	// scenarios
	task automatic t_reg;
		rd(CF, 32'h0, OK);
		rd(CT, 32'ha, OK);
		rd(12'h010, 32'h0, ER);
		wr(CF, 16'h0103, OK);
		rd(CF, 32'h0, OK);
		wr(WDK_OFF_KEY, 16'h0096, OK);
		wr(12'h020, 16'h0001, ER);
		for (int s = 0; s < 4; s++) begin
			wr(CF, 16'(s), OK);
			rd(CF, 32'(s), OK);
		end
		$display("t_reg done");
	endtask : t_reg
	task automatic t_div;
		wr(CF, 16'h0001, OK);
		wr(CT, 16'h0015, OK);
		pls(4'h2, 127);
		rd(ST, 32'h0, OK);
		pls(4'h2, 1);
		rd(ST, 32'h1, OK);
		wr(CF, 16'h0000, OK);
		wr(CT, 16'h0015, OK);
		pls(4'h1, 2047);
		rd(ST, 32'h0, OK);
		pls(4'h1, 1);
		rd(ST, 32'h1, OK);
		$display("t_div done");
	endtask : t_div
	task automatic t_run;
		wr(CF, 16'h0103, OK);
		wr(CT, 16'h0015, OK);
		rd(CT, 32'h0, OK);
		pls(4'h8, 5);
		rd(ST, 32'h5, OK);
		pls(4'h1, 3);
		rd(ST, 32'h5, OK);
		wr(CT, 16'h0005, OK);
		rd(ST, 32'h5, OK);
		i_debug <= 1'b1;
		pls(4'h8, 2);
		rd(ST, 32'h7, OK);
		wr(CF, 16'h0003, OK);
		pls(4'h8, 3);
		rd(ST, 32'h7, OK);
		i_debug <= 1'b0;
		pls(4'h8, 1);
		rd(ST, 32'h8, OK);
		wr(CT, 16'h000a, OK);
		rd(CT, 32'ha, OK);
		pls(4'h8, 2);
		rd(ST, 32'h8, OK);
		wr(WDK_OFF_KEY, 16'h0000, OK);
		wr(CT, 16'h0015, OK);
		rd(ST, 32'h8, OK);
		wr(WDK_OFF_KEY, 16'h0096, OK);
		$display("t_run done");
	endtask : t_run
	// periodic clearing keeps the count short of overflow
	task automatic t_kick;
		wr(WDK_OFF_KEY, 16'h0096, OK);
		wr(CF, 16'h0003, OK);
		wr(CT, 16'h0015, OK);
		wr(WDK_OFF_KEY, 16'h0000, OK);
		pls(4'h8, 1000);
		wr(WDK_OFF_KEY, 16'h0096, OK);
		wr(CT, 16'h0015, OK);
		pls(4'h8, 1000);
		chk("req", {31'h0, o_sys_reset_req}, 32'h0);
		rd(ST, 32'h3e8, OK);
		wr(CT, 16'h001a, OK);
		pls(4'h8, 3);
		rd(ST, 32'h0, OK);
		chk("req", {31'h0, o_sys_reset_req}, 32'h0);
		$display("t_kick done");
	endtask : t_kick
	task automatic t_ovf;
		wr(CT, 16'h0015, OK);
		rd(ST, 32'h0, OK);
		pls(4'h8, 1023);
		rd(ST, 32'h3ff, OK);
		chk("req", {31'h0, o_sys_reset_req}, 32'h0);
		pls(4'h8, 1);
		chk("req", {31'h0, o_sys_reset_req}, 32'h1);
		$display("t_ovf done");
	endtask : t_ovf
	// mid-run reset drops the sticky request and restores the stop code
	task automatic t_rst;
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk("req", {31'h0, o_sys_reset_req}, 32'h0);
		rd(CT, 32'ha, OK);
		rd(ST, 32'h0, OK);
		$display("t_rst done");
	endtask : t_rst
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		t_reg;
		t_div;
		t_run;
		t_kick;
		t_ovf;
		t_rst;
		print_verdict;
	end
endmodule : testbench
bind wdk_watchdog wdk_watchdog_properties #(.CNT_W(CNT_W)) u_chk (
	.i_clk(i_clk),
	.i_rst_b(i_rst_b),
	.i_src_pulse(i_src_pulse),
	.i_awvalid(i_awvalid),
	.o_awready(o_awready),
	.i_wvalid(i_wvalid),
	.o_wready(o_wready),
	.o_bvalid(o_bvalid),
	.i_bready(i_bready),
	.i_arvalid(i_arvalid),
	.o_arready(o_arready),
	.o_rdata(o_rdata),
	.o_rvalid(o_rvalid),
	.i_rready(i_rready),
	.o_sys_reset_req(o_sys_reset_req)
);
